// ---- hdl/otp_status_map.svh ----
// Purpose: Address map, field layout and reset values of the OTP/ECC status bank
// Assumes: Byte-wide registers on a 10-bit register address
// Notes: Definitions only
`ifndef OTP_STATUS_MAP_SVH
`define OTP_STATUS_MAP_SVH

// ==========================================================
// Widths
`define ADDR_W 10
`define DATA_W 8
`define NODE_W 6
`define EVT_W 3
`define IDX_W 4

// ==========================================================
// Result bytes: byte n sits at base plus n
`define ECC_RESULT_BASE 10'h2b0
`define ECC_RESULT_COUNT 4'h9
`define ECC_RESULT_LAST 4'h8
`define ECC_RESULT_SIX_OFS 10'h2b6
`define ECC_RESULT_SEVEN_OFS 10'h2b7
`define ECC_RESULT_EIGHT_OFS 10'h2b8

// ==========================================================
// OTP block address records and node number
`define OTP_SINGLE_FIX_BLOCK_OFS 10'h2b9
`define OTP_DOUBLE_ERR_BLOCK_OFS 10'h2ba
`define OWN_NODE_NUMBER_OFS 10'h2bb

// ==========================================================
// Event registers
`define EVENT_STATUS_OFS 10'h2c0
`define EVENT_ENABLE_OFS 10'h2c1
`define EVENT_CLEAR_OFS 10'h2c2
`define EVT_RESULT_BIT 0
`define EVT_SINGLE_BIT 1
`define EVT_DOUBLE_BIT 2

// ==========================================================
// Reset values and fillers
`define BYTE_RESET 8'h00
`define NODE_RESET 6'h00
`define EVT_RESET 3'h0
`define RSVD_NODE_BITS 2'h0
`define RSVD_EVT_BITS 5'h00
`define IDX_ZERO 4'h0

`endif

// ---- hdl/otp_status_pkg.sv ----
// Purpose: Types shared by the OTP/ECC status bank
// Assumes: otp_status_map.svh supplies the widths
// Notes: Carriers for engine updates and register bus requests
`include "otp_status_map.svh"

package otp_status_pkg;

  // ==========================================================
  // Self-test engine writes one result byte at a time
  typedef struct packed {
    logic valid;
    logic [`IDX_W-1:0] index;
    logic [`DATA_W-1:0] data;
  } ecc_result_write_type;

  // ==========================================================
  // Correction or detection event with the OTP block it hit
  typedef struct packed {
    logic valid;
    logic [`DATA_W-1:0] block;
  } otp_event_type;

  // ==========================================================
  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } reg_request_type;

endpackage

// ---- hdl/event_flags.sv ----
// Purpose: Sticky event status, enable gating and level interrupt
// Assumes: Set and clear come from logic on ref_clk_i
// Notes: A set in the clear cycle wins, so no event is lost
`timescale 1ns/1ns
`include "otp_status_map.svh"

module event_flags
  import otp_status_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [`EVT_W-1:0] set_i,
  input wire logic [`EVT_W-1:0] clear_i,
  input wire logic [`EVT_W-1:0] enable_i,
  output logic [`EVT_W-1:0] status_o,
  output logic irq_o
);

  logic [`EVT_W-1:0] status_q;
  logic [`EVT_W-1:0] status_d;
  logic irq_q;
  logic irq_d;

  // ==========================================================
  // Next status and interrupt level
  always_comb
  begin
    status_d = (status_q & ~clear_i) | set_i;
    irq_d = |(status_d & enable_i);
  end

  // Registers only
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      status_q <= `EVT_RESET;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  assign status_o = status_q;
  assign irq_o = irq_q;

endmodule

// ---- hdl/otp_ecc_and_address_status.sv ----
// Purpose: Read-only status bank for OTP ECC self-test, OTP error blocks
//          and the node's chain address
// Assumes: All update inputs come from logic on ref_clk_i, so none is
//          synchronised; the bus master never issues rd and wr together
// Notes: Read data stand one cycle after the read strobe and only then.
//        Block records are only meaningful while their fault flags,
//        kept outside this bank, are set
`timescale 1ns/1ns
`include "otp_status_map.svh"

// Behaviour
// - nine read-only self-test result bytes, reset zero
// - record block of latest single-bit correction
// - record block of latest double-bit detection
// - six-bit chain address, top two bits zero
module otp_ecc_and_address_status
  import otp_status_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`DATA_W-1:0] rdata_o,
  input wire ecc_result_write_type ecc_result_i,
  input wire otp_event_type single_bit_correction_i,
  input wire otp_event_type double_bit_detection_i,
  input wire logic [`NODE_W-1:0] node_number_i,
  output logic irq_o
);

  // ==========================================================
  // Helpers

  // True when the address falls inside the result byte window
  // The lower bound is redundant: below the base the subtraction wraps to an offset far past the window
  function automatic logic is_result_addr(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] ofs;
    ofs = a - `ECC_RESULT_BASE;
    is_result_addr = (a >= `ECC_RESULT_BASE) && (ofs < {6'h00, `ECC_RESULT_COUNT});
  endfunction

  // Index of the result byte behind an address in the window
  function automatic logic [`IDX_W-1:0] result_index(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] ofs;
    ofs = a - `ECC_RESULT_BASE;
    result_index = ofs[`IDX_W-1:0];
  endfunction

  // ==========================================================
  // Declarations
  reg_request_type req;
  logic [`DATA_W-1:0] result_q [`ECC_RESULT_COUNT];
  logic [`DATA_W-1:0] result_d [`ECC_RESULT_COUNT];
  logic [`DATA_W-1:0] single_block_q;
  logic [`DATA_W-1:0] single_block_d;
  logic [`DATA_W-1:0] double_block_q;
  logic [`DATA_W-1:0] double_block_d;
  logic [`NODE_W-1:0] node_q;
  logic [`NODE_W-1:0] node_d;
  logic [`EVT_W-1:0] enable_q;
  logic [`EVT_W-1:0] enable_d;
  logic [`DATA_W-1:0] rdata_q;
  logic [`DATA_W-1:0] rdata_d;
  logic [`EVT_W-1:0] evt_set;
  logic [`EVT_W-1:0] evt_clear;
  logic [`EVT_W-1:0] evt_status;
  logic result_hit;

  // Bus fields gathered into one carrier
  // Writes decode only enable and clear; every other offset falls through
  assign req.wr = wr_i;
  assign req.rd = rd_i;
  assign req.addr = addr_i;
  assign req.wdata = wdata_i;

  // ==========================================================
  // Self-test result bytes

  // An index beyond the last byte is dropped rather than aliased
  assign result_hit = ecc_result_i.valid && (ecc_result_i.index <= `ECC_RESULT_LAST);

  // Which bytes matter depends on the test direction, chosen outside this
  // bank; keeping all nine avoids tracking that direction here
  // Engine is the only writer; the bus never reaches these bytes
  always_comb
  begin
    for (int i = 0; i < `ECC_RESULT_COUNT; i++)
    begin
      result_d[i] = result_q[i];
    end
    if (result_hit)
    begin
      result_d[ecc_result_i.index] = ecc_result_i.data;
    end
  end

  // All nine kept so both test directions can be judged
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < `ECC_RESULT_COUNT; i++)
      begin
        result_q[i] <= `BYTE_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < `ECC_RESULT_COUNT; i++)
      begin
        result_q[i] <= result_d[i];
      end
    end
  end

  // ==========================================================
  // OTP block address records

  // Each record follows its own event; the latest event overwrites
  always_comb
  begin
    single_block_d = single_block_q;
    double_block_d = double_block_q;
    if (single_bit_correction_i.valid)
    begin
      single_block_d = single_bit_correction_i.block;
    end
    if (double_bit_detection_i.valid)
    begin
      double_block_d = double_bit_detection_i.block;
    end
  end

  // A stale record survives a cleared fault flag; software must check the
  // flag before trusting the block number
  // Validity is left to the fault flags kept elsewhere
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      single_block_q <= `BYTE_RESET;
      double_block_q <= `BYTE_RESET;
    end
    else
    begin
      single_block_q <= single_block_d;
      double_block_q <= double_block_d;
    end
  end

  // ==========================================================
  // Chain address

  // Tracks the addressing logic every cycle
  // Reserved top bits are filled in at the read mux, not stored
  always_comb
  begin
    node_d = node_number_i;
  end

  // Registered so a read sees a stable copy
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      node_q <= `NODE_RESET;
    end
    else
    begin
      node_q <= node_d;
    end
  end

  // ==========================================================
  // Event sources and software controls

  // Events: a result byte landed, a correction, a detection
  // A dropped out-of-range index raises no event either
  always_comb
  begin
    evt_set = `EVT_RESET;
    evt_set[`EVT_RESULT_BIT] = result_hit;
    evt_set[`EVT_SINGLE_BIT] = single_bit_correction_i.valid;
    evt_set[`EVT_DOUBLE_BIT] = double_bit_detection_i.valid;
  end

  // Clear register is write-only: a pulse, nothing is stored
  // A set in the same cycle still wins inside the flags
  always_comb
  begin
    evt_clear = `EVT_RESET;
    if (req.wr && (req.addr == `EVENT_CLEAR_OFS))
    begin
      evt_clear = req.wdata[`EVT_W-1:0];
    end
  end

  // Enable register is the only register software writes a value into; clear writes only drop status bits
  // Three bits, one per event source; upper write bits are ignored
  always_comb
  begin
    enable_d = enable_q;
    if (req.wr && (req.addr == `EVENT_ENABLE_OFS))
    begin
      enable_d = req.wdata[`EVT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      enable_q <= `EVT_RESET;
    end
    else
    begin
      enable_q <= enable_d;
    end
  end

  // Sticky status and the level interrupt. The next enable value feeds
  // the flags so an enable write moves irq_o on the same edge as the
  // enable register, with no cycle of stale interrupt level
  event_flags u_event_flags
  (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .set_i(evt_set),
    .clear_i(evt_clear),
    .enable_i(enable_d),
    .status_o(evt_status),
    .irq_o(irq_o)
  );

  // ==========================================================
  // Read decode

  // Data stand only in the cycle after the strobe, zero otherwise;
  // unmapped addresses read zero. Writes to status offsets fall
  // through every decoder above and leave all state alone.
  always_comb
  begin
    rdata_d = `BYTE_RESET;
    if (req.rd)
    begin
      if (is_result_addr(req.addr))
      begin
        rdata_d = result_q[result_index(req.addr)];
      end
      else if (req.addr == `OTP_SINGLE_FIX_BLOCK_OFS)
      begin
        rdata_d = single_block_q;
      end
      else if (req.addr == `OTP_DOUBLE_ERR_BLOCK_OFS)
      begin
        rdata_d = double_block_q;
      end
      else if (req.addr == `OWN_NODE_NUMBER_OFS)
      begin
        rdata_d = {`RSVD_NODE_BITS, node_q};
      end
      else if (req.addr == `EVENT_STATUS_OFS)
      begin
        rdata_d = {`RSVD_EVT_BITS, evt_status};
      end
      else if (req.addr == `EVENT_ENABLE_OFS)
      begin
        rdata_d = {`RSVD_EVT_BITS, enable_q};
      end
      else if (req.addr == `EVENT_CLEAR_OFS)
      begin
        rdata_d = `BYTE_RESET; // Clear is write-only
      end
      else
      begin
        rdata_d = `BYTE_RESET;
      end
    end
  end

  // Read data register
  // Returns to zero after one cycle so a stale byte is never mistaken
  // for a fresh answer
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rdata_q <= `BYTE_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Straight from the read data flop, no logic after it
  assign rdata_o = rdata_q;

endmodule

// ---- dv/otp_ecc_and_address_status_sva.sv ----
// Purpose: Port checks for the OTP/ECC status bank
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to every instance of the bank
`timescale 1ns/1ns
`include "otp_status_map.svh"

module status_checker
  import otp_status_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [`DATA_W-1:0] rdata_o,
  input wire ecc_result_write_type ecc_result_i,
  input wire otp_event_type single_bit_correction_i,
  input wire otp_event_type double_bit_detection_i,
  input wire logic [`NODE_W-1:0] node_number_i,
  input wire logic irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // ==========================================================
  // Update followed by a clean read of the same register
  sequence s_sgl;
    single_bit_correction_i.valid ##1
      (rd_i && addr_i == `OTP_SINGLE_FIX_BLOCK_OFS && !single_bit_correction_i.valid);
  endsequence
  sequence s_dbl;
    double_bit_detection_i.valid ##1
      (rd_i && addr_i == `OTP_DOUBLE_ERR_BLOCK_OFS && !double_bit_detection_i.valid);
  endsequence
  sequence s_res;
    (ecc_result_i.valid && ecc_result_i.index <= `ECC_RESULT_LAST) ##1
      (rd_i && !ecc_result_i.valid
        && addr_i == `ECC_RESULT_BASE + $past(ecc_result_i.index));
  endsequence

  // ==========================================================
  // Assertions
  chk_result_byte: assert property (s_res |=> rdata_o == $past(ecc_result_i.data, 2))
    else $error("result byte readback wrong");
  chk_single_block: assert property (s_sgl |=> rdata_o == $past(single_bit_correction_i.block, 2))
    else $error("single fix block wrong");
  chk_double_block: assert property (s_dbl |=> rdata_o == $past(double_bit_detection_i.block, 2))
    else $error("double error block wrong");
  chk_node_rsvd: assert property (rd_i && addr_i == `OWN_NODE_NUMBER_OFS |=> rdata_o[7:6] == 2'h0)
    else $error("node reserved bits set");
  // Stable input keeps the one-edge sampling delay out of the check
  chk_node_value: assert property (!$past(reset_i) && $stable(node_number_i) && rd_i
    && addr_i == `OWN_NODE_NUMBER_OFS |=> rdata_o[5:0] == $past(node_number_i))
    else $error("node number wrong");
  chk_write_quiet: assert property (wr_i |=> rdata_o == 8'h00)
    else $error("write drove read data");
  chk_ro_write: assert property (wr_i && addr_i >= `ECC_RESULT_BASE
    && addr_i <= `OWN_NODE_NUMBER_OFS && !ecc_result_i.valid && !single_bit_correction_i.valid
    && !double_bit_detection_i.valid |=> irq_o == $past(irq_o))
    else $error("status write moved irq");
endmodule

bind otp_ecc_and_address_status status_checker chk (.ref_clk_i, .reset_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .ecc_result_i, .single_bit_correction_i,
  .double_bit_detection_i, .node_number_i, .irq_o);

// ---- dv/otp_ecc_and_address_status_tb.sv ----
// Purpose: Self-checking bench for the OTP/ECC status bank
// Assumes: Inputs change by non-blocking assignment at rising edges
// Notes: Model holds expected bytes, blocks, event status and enables
`timescale 1ns/1ns
`include "otp_status_map.svh"

module otp_ecc_and_address_status_tb
  import otp_status_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [9:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic [7:0] rdata_o;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic irq_o;
  ecc_result_write_type ecc_result_i = '0;
  otp_event_type single_bit_correction_i = '0;
  otp_event_type double_bit_detection_i = '0;
  logic [5:0] node_number_i = '0;
  int err_count = 0;
  int n_compared = 0;
  logic [31:0] rnd = 32'h07e1;
  logic [7:0] res_m [9] = '{default: 8'h00};
  logic [7:0] sgl_m = 8'h00;
  logic [7:0] dbl_m = 8'h00;
  logic [2:0] st_m = 3'h0;
  logic [2:0] en_m = 3'h0;

  always #25 ref_clk_i = ~ref_clk_i;

  otp_ecc_and_address_status dut (.ref_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .ecc_result_i, .single_bit_correction_i,
    .double_bit_detection_i, .node_number_i, .irq_o);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] model(input logic [9:0] a);
    if (a >= `ECC_RESULT_BASE && a <= `ECC_RESULT_EIGHT_OFS)
      return res_m[a - `ECC_RESULT_BASE];
    case (a)
      `OTP_SINGLE_FIX_BLOCK_OFS: return sgl_m;
      `OTP_DOUBLE_ERR_BLOCK_OFS: return dbl_m;
      `OWN_NODE_NUMBER_OFS: return {2'h0, node_number_i};
      `EVENT_STATUS_OFS: return {5'h00, st_m};
      `EVENT_ENABLE_OFS: return {5'h00, en_m};
      default: return 8'h00;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Bus and engine drivers
  task automatic rd(input logic [9:0] a);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, model(a));
  endtask

  // Irq is checked after every write so a stray side effect shows
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
    if (a == `EVENT_ENABLE_OFS)
      en_m = d[2:0];
    if (a == `EVENT_CLEAR_OFS)
      st_m &= ~d[2:0];
    check({7'h00, irq_o}, {7'h00, |(st_m & en_m)});
  endtask

  // Each update is read back at once, the tightest spacing allowed
  task automatic evt(input int k, input logic [3:0] i, input logic [7:0] d);
    logic [9:0] a;
    a = (k == 1) ? `OTP_SINGLE_FIX_BLOCK_OFS
      : (k == 2) ? `OTP_DOUBLE_ERR_BLOCK_OFS : `ECC_RESULT_BASE + 10'(i);
    @(posedge ref_clk_i);
    if (k == 0)
      ecc_result_i <= {1'b1, i, d};
    if (k == 1)
      single_bit_correction_i <= {1'b1, d};
    if (k == 2)
      double_bit_detection_i <= {1'b1, d};
    @(posedge ref_clk_i);
    ecc_result_i <= '0;
    single_bit_correction_i <= '0;
    double_bit_detection_i <= '0;
    rd_i <= 1'b1;
    addr_i <= a;
    #1;
    if (k == 0 && i <= `ECC_RESULT_LAST)
      res_m[i] = d;
    if (k == 1)
      sgl_m = d;
    if (k == 2)
      dbl_m = d;
    if (k != 0 || i <= `ECC_RESULT_LAST)
      st_m[k] = 1'b1;
    check({7'h00, irq_o}, {7'h00, |(st_m & en_m)});
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, model(a));
  endtask

  // Covers every status byte plus the holes around them
  task automatic scan();
    for (int a = `ECC_RESULT_BASE; a <= 'h2c2; a++)
      rd(a[9:0]);
    rd(10'h3ff);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    scan();
    // Index nine lies past the last byte and must be dropped
    for (int i = 0; i < 10; i++)
    begin
      rnd = lfsr(rnd);
      evt(0, 4'(i), rnd[7:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      evt(1 + i % 2, 4'h0, rnd[7:0]);
    end
    wr(`EVENT_ENABLE_OFS, 8'h07);
    scan();
    wr(`EVENT_CLEAR_OFS, 8'h07);
    wr(`EVENT_ENABLE_OFS, 8'h02);
    evt(2, 4'h0, 8'hff);
    evt(1, 4'h0, 8'h00);
    scan();
    wr(`EVENT_CLEAR_OFS, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      @(posedge ref_clk_i);
      node_number_i <= rnd[5:0];
      repeat (2) @(posedge ref_clk_i);
      rd(`OWN_NODE_NUMBER_OFS);
    end
    // Interrupt held high so a stray status write would show on irq_o
    wr(`EVENT_ENABLE_OFS, 8'h04);
    for (int a = `ECC_RESULT_BASE; a <= 'h2c2; a++)
    begin
      rnd = lfsr(rnd);
      if (a != `EVENT_ENABLE_OFS && a != `EVENT_CLEAR_OFS)
        wr(a[9:0], rnd[7:0]);
    end
    scan();
    give_verdict();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    give_verdict();
  end
endmodule
